// >>> dual_dac_defs.svh
// Constants for the dual converter serial word link.
// Assumes inclusion by bare name from the package and both ends.
`ifndef DUAL_DAC_DEFS_SVH
`define DUAL_DAC_DEFS_SVH
`define WORD_BITS 16
`define CODE_BITS 12
`define POS_TARGET_HIGH 15
`define POS_FAST_SETTLE 14
`define POS_POWER_DOWN 13
`define POS_TARGET_LOW 12
`define CODE_RESET 12'h000
`define SCLK_HALF_DIV 6
`define CS_GAP_CYCLES 13
`endif

// >>> dual_dac_device.sv
// Converter side: serial word decoder and latch control.
// Assumes link pins are asynchronous and are synchronised here.
// Functional notes
// - Select low enables input; high ignores clock
// - Shift on falling clock, MSB first
// - Transfer after sixteen bits or early select rise
// - Reset clears latches and controls to zero
// - Word holds four control, twelve data bits
// - Low twelve bits are new code
// - Select 00 writes buffer and channel B
// - Select 01 writes buffer only
// - Select 10 writes A, loads B from buffer
// - Bit 14 chooses fast or slow settling
// - Bit 13 requests power down
// - Update on rising edge after sixteenth fall
// - Simultaneous update changes both outputs together
// - Host writes buffer then simultaneous A word
// - Host drives select low before clocking
// - Byte hosts keep select low over two
// - Code is unsigned zero to 4095
`timescale 1ns/10ps
`include "dual_dac_defs.svh"
module dual_dac_device #(
    parameter int WORD_BITS = `WORD_BITS,
    parameter int CODE_BITS = `CODE_BITS
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Link
    dual_dac_link_if.device link,
    // Converter controls
    output logic [CODE_BITS-1:0] first_analog_output_out,
    output logic [CODE_BITS-1:0] second_analog_output_out,
    output logic fast_settle_select_out,
    output logic power_down_request_out,
    output logic update_out
);
    // The decoder is written for one word layout; other sizes are refused
    if (WORD_BITS != 16) begin : g_bad_word
        $error("dual_dac_device decodes only 16-bit words");
    end
    if (CODE_BITS != 12) begin : g_bad_code
        $error("dual_dac_device decodes only 12-bit codes");
    end
    if (`POS_TARGET_LOW != CODE_BITS) begin : g_bad_layout
        $error("dual_dac_device needs the control bits right above the code");
    end

    typedef struct packed {
        logic [1:0] cs_n_sync;
        logic [1:0] sclk_sync;
        logic [1:0] din_sync;
        logic sclk_prev;
        logic cs_n_prev;
        logic [WORD_BITS-1:0] shift;
        logic [4:0] count;
        logic pending;
        logic [CODE_BITS-1:0] chan_a;
        logic [CODE_BITS-1:0] chan_b;
        logic [CODE_BITS-1:0] hold_buf;
        logic fast;
        logic pwr_down;
        logic update;
    } dev_state_type;

    dev_state_type state_r;
    dev_state_type state_nxt;

    // Power-on state: latches and controls cleared, pin stages at idle levels
    // The clock stage parks high like the pin, so reset release shows no edge
    function automatic dev_state_type reset_state();
        dev_state_type r;
        r.cs_n_sync = 2'b11;
        r.sclk_sync = 2'b11;
        r.din_sync = 2'b00;
        r.sclk_prev = 1'b1;
        r.cs_n_prev = 1'b1;
        r.shift = '0;
        r.count = 5'd0;
        r.pending = 1'b0;
        r.chan_a = `CODE_RESET;
        r.chan_b = `CODE_RESET;
        r.hold_buf = `CODE_RESET;
        r.fast = 1'b0;
        r.pwr_down = 1'b0;
        r.update = 1'b0;
        return r;
    endfunction

    // Edges are taken between the second synchroniser stage and its delayed copy
    function automatic logic edge_fall(input logic prev_level, input logic level);
        return prev_level && !level;
    endfunction

    function automatic logic edge_rise(input logic prev_level, input logic level);
        return !prev_level && level;
    endfunction

    // Select bits sit apart in the word: high at bit 15, low at bit 12
    function automatic dual_dac_pkg::target_type word_target(input logic [WORD_BITS-1:0] w);
        return dual_dac_pkg::target_type'({w[`POS_TARGET_HIGH], w[`POS_TARGET_LOW]});
    endfunction

    function automatic logic [CODE_BITS-1:0] word_code(input logic [WORD_BITS-1:0] w);
        return w[CODE_BITS-1:0];
    endfunction

    // True on the fall that brings in the last bit of a word
    function automatic logic last_bit(input logic [4:0] cnt);
        return cnt == 5'(WORD_BITS - 1);
    endfunction

    // Speed and power-down ride on every word, reserved selects included
    function automatic dev_state_type take_controls(input dev_state_type s);
        dev_state_type r;
        r = s;
        r.fast = s.shift[`POS_FAST_SETTLE];
        r.pwr_down = s.shift[`POS_POWER_DOWN];
        r.update = 1'b1;
        return r;
    endfunction

    // Applies one received word to the latches
    function automatic dev_state_type apply_word(input dev_state_type s);
        dev_state_type r;
        dual_dac_pkg::target_type tgt;
        logic [CODE_BITS-1:0] code;
        r = take_controls(s);
        tgt = word_target(s.shift);
        code = word_code(s.shift);
        case (tgt)
            dual_dac_pkg::tgt_b_and_buf: begin
                r.hold_buf = code;
                r.chan_b = code;
            end
            dual_dac_pkg::tgt_buf_only: begin
                r.hold_buf = code;
            end
            dual_dac_pkg::tgt_a_and_b_from_buf: begin
                r.chan_a = code;
                r.chan_b = s.hold_buf;
            end
            default: begin
                // Reserved code leaves the latches alone
            end
        endcase
        return r;
    endfunction

    always_comb begin
        logic cs_n_pin;
        logic sclk_pin;
        logic din_pin;
        logic sclk_fall;
        logic sclk_rise;
        logic cs_rise;
        cs_n_pin = state_r.cs_n_sync[1];
        sclk_pin = state_r.sclk_sync[1];
        din_pin = state_r.din_sync[1];
        sclk_fall = edge_fall(state_r.sclk_prev, sclk_pin);
        sclk_rise = edge_rise(state_r.sclk_prev, sclk_pin);
        cs_rise = edge_rise(state_r.cs_n_prev, cs_n_pin);
        state_nxt = state_r;
        state_nxt.update = 1'b0;
        // Only the second stage of each synchroniser feeds logic
        state_nxt.cs_n_sync = {state_r.cs_n_sync[0], link.cs_n};
        state_nxt.sclk_sync = {state_r.sclk_sync[0], link.sclk};
        state_nxt.din_sync = {state_r.din_sync[0], link.din};
        state_nxt.sclk_prev = sclk_pin;
        state_nxt.cs_n_prev = cs_n_pin;
        if (cs_n_pin) begin
            // Select high: clock and data ignored
            state_nxt.count = 5'd0;
            state_nxt.pending = 1'b0;
            if (cs_rise && state_r.count != 5'd0) begin
                // A full word not yet applied, or a partial one, is transferred now
                state_nxt = apply_word(state_nxt);
                state_nxt.count = 5'd0;
            end
        end else if (state_r.pending && sclk_rise) begin
            // Latches move three clocks after the pin rise, on synchronised edges
            state_nxt = apply_word(state_nxt);
            state_nxt.pending = 1'b0;
            state_nxt.count = 5'd0;
        end else if (sclk_fall && !state_r.pending) begin
            state_nxt.shift = {state_r.shift[WORD_BITS-2:0], din_pin};
            if (last_bit(state_r.count)) begin
                state_nxt.pending = 1'b1;
            end
            state_nxt.count = state_r.count + 5'd1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_r <= reset_state();
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs come straight from the state register
    assign first_analog_output_out = state_r.chan_a;
    assign second_analog_output_out = state_r.chan_b;
    assign fast_settle_select_out = state_r.fast;
    assign power_down_request_out = state_r.pwr_down;
    assign update_out = state_r.update;
endmodule

// >>> dual_dac_host.sv
// Host side: serial port that frames and sends one 16-bit word.
// Assumes the user keeps the request high until accepted.
`timescale 1ns/10ps
`include "dual_dac_defs.svh"
module dual_dac_host #(
    parameter int WORD_BITS = `WORD_BITS,
    parameter int HALF_DIV = `SCLK_HALF_DIV,
    parameter int GAP_CYCLES = `CS_GAP_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // User request
    input wire logic send_valid_in,
    input wire logic [WORD_BITS-1:0] send_word_in,
    output logic send_ready_out,
    output logic busy_out,
    // Link
    dual_dac_link_if.host link
);
    // The divider is eight bits; a short half period would outrun the far synchroniser
    if (WORD_BITS != 16 || HALF_DIV < 4 || HALF_DIV > 255 || GAP_CYCLES > 255) begin : g_bad
        $error("dual_dac_host parameters out of range");
    end

    typedef struct packed {
        dual_dac_pkg::host_state_type st;
        logic [WORD_BITS-1:0] shift;
        logic [4:0] bits_left;
        logic [7:0] div;
        logic cs_n;
        logic sclk;
        logic din;
    } host_reg_type;

    host_reg_type state_r;
    host_reg_type state_nxt;

    always_comb begin
        logic tick;
        tick = (state_r.div == 8'(HALF_DIV - 1));
        state_nxt = state_r;
        state_nxt.div = tick ? 8'd0 : state_r.div + 8'd1;
        case (state_r.st)
            dual_dac_pkg::st_idle: begin
                state_nxt.div = 8'd0;
                if (send_valid_in) begin
                    // Select falls before any clock edge
                    state_nxt.cs_n = 1'b0;
                    state_nxt.shift = send_word_in;
                    state_nxt.din = send_word_in[WORD_BITS-1];
                    state_nxt.bits_left = 5'(WORD_BITS);
                    state_nxt.st = dual_dac_pkg::st_select;
                end
            end
            dual_dac_pkg::st_select: begin
                if (tick) begin
                    state_nxt.sclk = 1'b0;
                    state_nxt.st = dual_dac_pkg::st_shift_low;
                end
            end
            dual_dac_pkg::st_shift_low: begin
                if (tick) begin
                    state_nxt.sclk = 1'b1;
                    state_nxt.bits_left = state_r.bits_left - 5'd1;
                    state_nxt.shift = {state_r.shift[WORD_BITS-2:0], 1'b0};
                    state_nxt.st = dual_dac_pkg::st_shift_high;
                end
            end
            dual_dac_pkg::st_shift_high: begin
                if (tick) begin
                    if (state_r.bits_left == 5'd0) begin
                        // Select held low over all sixteen bits
                        state_nxt.cs_n = 1'b1;
                        state_nxt.st = dual_dac_pkg::st_gap;
                    end else begin
                        state_nxt.din = state_r.shift[WORD_BITS-1];
                        state_nxt.sclk = 1'b0;
                        state_nxt.st = dual_dac_pkg::st_shift_low;
                    end
                end
            end
            dual_dac_pkg::st_gap: begin
                // The gap outlasts one half period, so the divider must not wrap here
                state_nxt.div = state_r.div + 8'd1;
                if (state_r.div == 8'(GAP_CYCLES)) begin
                    state_nxt.st = dual_dac_pkg::st_idle;
                end
            end
            default: begin
                state_nxt.st = dual_dac_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_r <= '0;
            state_r.st <= dual_dac_pkg::st_idle;
            state_r.cs_n <= 1'b1;
            state_r.sclk <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign send_ready_out = (state_r.st == dual_dac_pkg::st_idle);
    assign busy_out = (state_r.st != dual_dac_pkg::st_idle);
    assign link.cs_n = state_r.cs_n;
    assign link.sclk = state_r.sclk;
    assign link.din = state_r.din;
endmodule

// >>> dual_dac_link_if.sv
// Three-wire link between a host serial port and the converter.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface dual_dac_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    modport host (output cs_n, output sclk, output din);
    modport device (input cs_n, input sclk, input din);
endinterface

// >>> dual_dac_pkg.sv
// Types shared by both ends of the serial word link.
// Assumes dual_dac_defs.svh is on the include path.
`include "dual_dac_defs.svh"
package dual_dac_pkg;
    typedef enum logic [1:0] {
        tgt_b_and_buf,
        tgt_buf_only,
        tgt_a_and_b_from_buf,
        tgt_reserved
    } target_type;
    typedef enum {
        st_idle,
        st_select,
        st_shift_low,
        st_shift_high,
        st_gap
    } host_state_type;
endpackage

// >>> dual_dac_serial_word_decoder_asserts.sv
// Checker for the serial word link and the converter outputs.
// Assumes it sits beside the link interface in the bench.
`timescale 1ns/10ps
module dual_dac_serial_word_decoder_asserts (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    // Converter controls
    input wire logic [11:0] first_analog_output_out,
    input wire logic [11:0] second_analog_output_out,
    input wire logic fast_settle_select_out,
    input wire logic power_down_request_out,
    input wire logic update_out
);
    logic [15:0] word_r;
    logic [11:0] hold_r;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Bit and clock change together on the wire, so the new bit is taken
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            word_r <= 16'h0000;
            hold_r <= 12'h000;
        end else begin
            if (!cs_n && $fell(sclk)) begin
                word_r <= {word_r[14:0], din};
            end
            if (update_out && !word_r[15]) begin
                hold_r <= word_r[11:0];
            end
        end
    end
    chk_select_held: assert property ($fell(cs_n) |-> !cs_n [*8])
        else $error("select released early");
    chk_clock_parked: assert property (cs_n && $past(cs_n) |-> sclk)
        else $error("serial clock moves outside a frame");
    chk_word_applied: assert property ($fell(cs_n) |-> ##[150:300] update_out)
        else $error("word not applied in time");
    chk_speed_taken: assert property (update_out |-> fast_settle_select_out == word_r[14])
        else $error("speed bit not applied");
    chk_power_taken: assert property (update_out |-> power_down_request_out == word_r[13])
        else $error("power down bit not applied");
    chk_b_direct: assert property (update_out && {word_r[15], word_r[12]} == 2'b00
        |-> second_analog_output_out == word_r[11:0])
        else $error("channel B not written");
    chk_buffer_only: assert property (update_out && {word_r[15], word_r[12]} == 2'b01
        |-> first_analog_output_out == $past(first_analog_output_out, 2)
        && second_analog_output_out == $past(second_analog_output_out, 2))
        else $error("buffer write moved an output");
    chk_a_and_b: assert property (update_out && {word_r[15], word_r[12]} == 2'b10
        |-> first_analog_output_out == word_r[11:0] && second_analog_output_out == hold_r)
        else $error("simultaneous update wrong");
    chk_change_cause: assert property ($changed(first_analog_output_out) |-> update_out)
        else $error("channel A changed without a word");
    chk_no_reserved: assert property (update_out |-> {word_r[15], word_r[12]} != 2'b11)
        else $error("reserved select sent");
endmodule

// >>> test_dual_dac_serial_word_decoder.sv
// Bench joining host and converter ends over the link interface.
// Assumes the package, defines and both ends are compiled first.
`timescale 1ns/10ps
module test_dual_dac_serial_word_decoder;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic send_valid_in = 1'b0;
    logic [15:0] send_word_in = 16'h0000;
    logic send_ready_out;
    logic busy_out;
    logic [11:0] a_out;
    logic [11:0] b_out;
    logic fast_out;
    logic power_out;
    logic update_out;
    logic [11:0] exp_a = 12'h000;
    logic [11:0] exp_b = 12'h000;
    logic [11:0] exp_buf = 12'h000;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    dual_dac_link_if link();
    dual_dac_host i_dual_dac_host (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .send_valid_in(send_valid_in), .send_word_in(send_word_in),
        .send_ready_out(send_ready_out), .busy_out(busy_out), .link(link.host));
    dual_dac_device i_dual_dac_device (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .link(link.device), .first_analog_output_out(a_out), .second_analog_output_out(b_out),
        .fast_settle_select_out(fast_out), .power_down_request_out(power_out),
        .update_out(update_out));
    dual_dac_serial_word_decoder_asserts i_dual_dac_serial_word_decoder_asserts (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .cs_n(link.cs_n), .sclk(link.sclk),
        .din(link.din), .first_analog_output_out(a_out), .second_analog_output_out(b_out),
        .fast_settle_select_out(fast_out), .power_down_request_out(power_out),
        .update_out(update_out));
    always #2 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR %0t %s: saw %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic expect_outs();
        check(a_out, exp_a, "channel A");
        check(b_out, exp_b, "channel B");
    endtask
    // Whole word through the host, then wait for the converter to apply it
    task automatic send(input logic [15:0] w);
        int k;
        k = 0;
        while (send_ready_out !== 1'b1 && k < 400) begin
            @(posedge ref_clk_in);
            #1;
            k++;
        end
        send_valid_in = 1'b1;
        send_word_in = w;
        @(posedge ref_clk_in);
        #1;
        send_valid_in = 1'b0;
        check({busy_out, send_ready_out, link.cs_n}, 3'b100, "host framing");
        k = 0;
        while (update_out !== 1'b1 && k < 400) begin
            @(posedge ref_clk_in);
            #1;
            k++;
        end
        check(update_out, 1'b1, "update pulse");
        check(fast_out, w[14], "speed");
        check(power_out, w[13], "power down");
        @(posedge ref_clk_in);
        #1;
        check(update_out, 1'b0, "update width");
    endtask
    task automatic t_reset();
        expect_outs();
        check({fast_out, power_out, update_out}, 3'b000, "controls after reset");
    endtask
    task automatic t_direct_b();
        send(16'h4ABC);
        exp_b = 12'hABC;
        exp_buf = 12'hABC;
        expect_outs();
    endtask
    task automatic t_buffer_only();
        send(16'h1123);
        exp_buf = 12'h123;
        expect_outs();
    endtask
    task automatic t_simultaneous();
        send(16'h8456);
        exp_a = 12'h456;
        exp_b = exp_buf;
        expect_outs();
    endtask
    task automatic t_power_and_limits();
        send(16'h2FFF);
        exp_b = 12'hFFF;
        exp_buf = 12'hFFF;
        expect_outs();
        send(16'hC000);
        exp_a = 12'h000;
        expect_outs();
    endtask
    task automatic t_reset_again();
        sys_rst_in = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        exp_a = 12'h000;
        exp_b = 12'h000;
        exp_buf = 12'h000;
        t_reset();
        sys_rst_in = 1'b0;
        send(16'h8ABC);
        exp_a = 12'hABC;
        exp_b = exp_buf;
        expect_outs();
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_in);
        #1;
        t_reset();
        sys_rst_in = 1'b0;
        t_direct_b();
        t_buffer_only();
        t_simultaneous();
        t_power_and_limits();
        t_reset_again();
        final_report();
    end
endmodule
